// >>> core/sdc_sdram_front.sv
/*
 * Device-side front end of a four-bank 16-bit synchronous DRAM: command
 * decode, clock suspend, power-down and self-refresh, bursts.
 * Assumes the controller drives link_clk and all pins on it; core_clk is
 * a free-running clock used to watch clock-enable while the link sleeps.
 */
`include "sdc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdc_sdram_front #(
   parameter int ROW_BITS = `SDC_ROW_BITS,
   parameter int COL_BITS = `SDC_COL_BITS
) (
   // Core side
   input wire logic core_clk,
   input wire logic rst,
   output sdc_pkg::sdc_status_t status_q,
   // Memory pins, timed by the controller clock
   input wire logic link_clk,
   input wire logic cke,
   input wire sdc_pkg::sdc_pins_t pins,
   input wire logic bank_select_lsb,
   input wire logic bank_select_msb,
   input wire logic [`SDC_ADDR_W-1:0] addr,
   input wire logic [1:0] dqm,
   input wire logic [`SDC_DQ_W-1:0] dq_in,
   // Data out
   output logic [`SDC_DQ_W-1:0] dq_out_q,
   output logic dq_oe_q
);
   import sdc_pkg::*;

   localparam int AW = 2 + ROW_BITS + COL_BITS;
   localparam int TRP_CYC = (`SDC_TRP_NS + `SDC_LINK_NS - 1) / `SDC_LINK_NS;

   // -----------------------------------------------------------------
   // Link-domain state
   // -----------------------------------------------------------------
   logic [`SDC_DQ_W-1:0] mem [0:(1<<AW)-1];
   logic [ROW_BITS-1:0] row_q [0:`SDC_BANKS-1];
   logic [`SDC_BANKS-1:0] open_q;
   logic [`SDC_ADDR_W-1:0] mr_q;
   sdc_pwr_t pwr_q;
   logic cke_prev_q, lp_q, w1_q, w2_q;
   logic bst_active_q, bst_wr_q, bst_ap_q;
   logic [1:0] bst_bank_q, ap_bank_q;
   logic [COL_BITS-1:0] bst_start_q, bst_idx_q;
   logic ap_busy_q;
   logic [3:0] ap_cnt_q;
   logic v0_q, v1_q;
   logic [`SDC_DQ_W-1:0] d0_q, d1_q;
   sdc_status_t lk_st_q;

   // Core-domain state
   logic c1_q, c2_q, c3_q, l1_q, l2_q, wake_q;
   sdc_status_t s1_q;

   // -----------------------------------------------------------------
   // Command decode and access control
   // -----------------------------------------------------------------
   sdc_cmd_t cmd;
   logic [1:0] bank;
   logic run, idle_all, lp_enter, cmd_ok, cl3, page;
   logic acc_rd, acc_wr, acc_new, acc_bst, cont, acc_wr_now, acc_rd_now;
   logic burst_last, ap_start, ap_done;
   logic [2:0] bl;
   logic [COL_BITS-1:0] len_m1, seq_col, a_col;
   logic [1:0] a_bank;
   logic [AW-1:0] a_idx;

   always_comb begin
      if (pins.cs_n) begin
         cmd = CMD_DESEL;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            `SDC_OP_ACT: cmd = CMD_ACT;
            `SDC_OP_RD: cmd = CMD_RD;
            `SDC_OP_WR: cmd = CMD_WR;
            `SDC_OP_BST: cmd = CMD_BST;
            `SDC_OP_PRE: cmd = CMD_PRE;
            `SDC_OP_REF: cmd = CMD_REF;
            `SDC_OP_MRS: cmd = CMD_MRS;
            default: cmd = CMD_NOP;
         endcase
      end
   end

   assign bank = {bank_select_msb, bank_select_lsb};
   assign bl = mr_q[`SDC_MR_BL_MSB:`SDC_MR_BL_LSB];
   assign page = (bl == `SDC_BL_PAGE);
   assign cl3 = (mr_q[`SDC_MR_CL_MSB:`SDC_MR_CL_LSB] == `SDC_CL3);

   always_comb begin
      case (bl)
         `SDC_BL2: len_m1 = COL_BITS'(1);
         `SDC_BL4: len_m1 = COL_BITS'(3);
         `SDC_BL8: len_m1 = COL_BITS'(7);
         `SDC_BL_PAGE: len_m1 = '1;
         default: len_m1 = '0;
      endcase
   end

   // The internal clock runs in a cycle only if clock-enable was high
   // at the previous edge.
   assign run = cke_prev_q && (pwr_q == PWR_ACTIVE);
   assign idle_all = (open_q == '0) && !bst_active_q && !ap_busy_q;
   // Entry waits for the wake level to drop, so a stale wake from the
   // core side cannot bounce the device straight back out.
   assign lp_enter = run && !cke && idle_all && !w2_q;
   assign cmd_ok = run && !lp_enter;
   // Reads and writes to a closed bank are dropped.
   assign acc_rd = cmd_ok && (cmd == CMD_RD) && open_q[bank];
   assign acc_wr = cmd_ok && (cmd == CMD_WR) && open_q[bank];
   assign acc_new = acc_rd || acc_wr;
   assign acc_bst = cmd_ok && (cmd == CMD_BST) && bst_active_q;
   assign cont = cmd_ok && bst_active_q && !acc_new && !acc_bst;
   assign acc_wr_now = acc_wr || (cont && bst_wr_q);
   assign acc_rd_now = acc_rd || (cont && !bst_wr_q);
   assign burst_last = (acc_new && (len_m1 == '0))
                     || (cont && !page && (bst_idx_q == len_m1));
   assign ap_start = burst_last
                   && (acc_new ? addr[`SDC_AP_BIT] : bst_ap_q);
   assign ap_done = ap_busy_q && (ap_cnt_q == 4'h1);

   sdc_burst_col #(
      .COL_BITS(COL_BITS)
   ) u_col (
      .start(bst_start_q),
      .idx(bst_idx_q),
      .len_m1(len_m1),
      .interleave(mr_q[`SDC_MR_BT]),
      .col(seq_col)
   );

   assign a_col = acc_new ? addr[COL_BITS-1:0] : seq_col;
   assign a_bank = acc_new ? bank : bst_bank_q;
   assign a_idx = {a_bank, row_q[a_bank], a_col};

   // -----------------------------------------------------------------
   // Power state
   // -----------------------------------------------------------------
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         pwr_q <= PWR_ACTIVE;
         cke_prev_q <= 1'b1;
         lp_q <= 1'b0;
      end else begin
         lp_q <= (pwr_q != PWR_ACTIVE);
         case (pwr_q)
            PWR_ACTIVE: begin
               cke_prev_q <= cke;
               if (lp_enter) begin
                  pwr_q <= (cmd == CMD_REF) ? PWR_SELF : PWR_DOWN;
               end
            end
            default: begin
               // Pins are not looked at here; only the wake level from
               // the core side ends the mode.
               cke_prev_q <= 1'b0;
               if (w2_q) begin
                  pwr_q <= PWR_ACTIVE;
                  cke_prev_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Banks, mode word and auto-close timer
   // -----------------------------------------------------------------
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         open_q <= '0;
         mr_q <= `SDC_MR_RESET;
      end else begin
         if (cmd_ok && (cmd == CMD_MRS) && idle_all) begin
            mr_q <= addr;
         end
         if (cmd_ok && (cmd == CMD_ACT)) begin
            open_q[bank] <= 1'b1;
         end
         if (cmd_ok && (cmd == CMD_PRE)) begin
            if (addr[`SDC_AP_BIT]) begin
               open_q <= '0;
            end else begin
               open_q[bank] <= 1'b0;
            end
         end
         if (ap_done) begin
            open_q[ap_bank_q] <= 1'b0;
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (cmd_ok && (cmd == CMD_ACT)) begin
         row_q[bank] <= addr[ROW_BITS-1:0];
      end
   end

   // Precharge is self-timed and keeps counting through a suspend.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         ap_busy_q <= 1'b0;
         ap_bank_q <= 2'h0;
         ap_cnt_q <= 4'h0;
      end else if (ap_start) begin
         ap_busy_q <= 1'b1;
         ap_bank_q <= a_bank;
         ap_cnt_q <= 4'(TRP_CYC);
      end else if (ap_busy_q) begin
         ap_cnt_q <= ap_cnt_q - 4'h1;
         if (ap_done) begin
            ap_busy_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Burst sequencing
   // -----------------------------------------------------------------
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         bst_active_q <= 1'b0;
         bst_wr_q <= 1'b0;
         bst_ap_q <= 1'b0;
         bst_bank_q <= 2'h0;
         bst_start_q <= '0;
         bst_idx_q <= '0;
      end else if (acc_new) begin
         bst_wr_q <= acc_wr;
         bst_ap_q <= addr[`SDC_AP_BIT];
         bst_bank_q <= bank;
         bst_start_q <= addr[COL_BITS-1:0];
         bst_idx_q <= COL_BITS'(1);
         bst_active_q <= (len_m1 != '0);
      end else if (acc_bst) begin
         bst_active_q <= 1'b0;
      end else if (cont) begin
         bst_idx_q <= bst_idx_q + COL_BITS'(1);
         if (burst_last) begin
            bst_active_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Data path
   // -----------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      for (int b = 0; b < 2; b++) begin
         if (acc_wr_now && !dqm[b]) begin
            mem[a_idx][b*8 +: 8] <= dq_in[b*8 +: 8];
         end
      end
      if (run) begin
         d0_q <= mem[a_idx];
         d1_q <= d0_q;
      end
   end

   // Suspended cycles leave the whole read pipe where it is.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         v0_q <= 1'b0;
         v1_q <= 1'b0;
         dq_oe_q <= 1'b0;
         dq_out_q <= '0;
      end else if (run) begin
         v0_q <= acc_rd_now;
         v1_q <= v0_q;
         dq_oe_q <= cl3 ? v1_q : v0_q;
         dq_out_q <= cl3 ? d1_q : d0_q;
      end else if (pwr_q != PWR_ACTIVE) begin
         dq_oe_q <= 1'b0;
         v0_q <= 1'b0;
         v1_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Domain crossing
   // -----------------------------------------------------------------
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         w1_q <= 1'b0;
         w2_q <= 1'b0;
         lk_st_q <= '0;
      end else begin
         w1_q <= wake_q;
         w2_q <= w1_q;
         lk_st_q <= '{power_down: pwr_q == PWR_DOWN,
                      self_refresh: pwr_q == PWR_SELF,
                      burst_busy: bst_active_q,
                      banks_open: open_q};
      end
   end

   // The link clock is stopped in low power, so clock-enable is watched
   // from the free-running core clock instead.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c1_q <= 1'b0;
         c2_q <= 1'b0;
         c3_q <= 1'b0;
         l1_q <= 1'b0;
         l2_q <= 1'b0;
         wake_q <= 1'b0;
         s1_q <= '0;
         status_q <= '0;
      end else begin
         c1_q <= cke;
         c2_q <= c1_q;
         c3_q <= c2_q;
         l1_q <= lp_q;
         l2_q <= l1_q;
         s1_q <= lk_st_q;
         status_q <= s1_q;
         if (l2_q && c2_q && c3_q) begin
            wake_q <= 1'b1;
         end else if (!l2_q) begin
            wake_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_suspend;
      @(posedge link_clk) disable iff (rst)
      (pwr_q == PWR_ACTIVE && !cke && !lp_enter) |=> !run;
   endproperty
   a_suspend: assert property (p_suspend) else $error("no suspend");

   property p_freeze;
      @(posedge link_clk) disable iff (rst)
      (!run && pwr_q == PWR_ACTIVE) |=>
         $stable(bst_idx_q) && $stable(dq_out_q) && $stable(dq_oe_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("moved in suspend");

   property p_lp_idle;
      @(posedge link_clk) disable iff (rst)
      (pwr_q == PWR_ACTIVE ##1 pwr_q != PWR_ACTIVE) |-> $past(open_q) == '0;
   endproperty
   a_lp_idle: assert property (p_lp_idle) else $error("sleep, bank open");

   property p_lp_deaf;
      @(posedge link_clk) disable iff (rst)
      (pwr_q != PWR_ACTIVE) |=> $stable(open_q) && $stable(mr_q)
         && !bst_active_q;
   endproperty
   a_lp_deaf: assert property (p_lp_deaf) else $error("acted in sleep");

   property p_wake;
      @(posedge core_clk) disable iff (rst)
      $rose(wake_q) |-> $past(l2_q) && $past(c3_q);
   endproperty
   a_wake: assert property (p_wake) else $error("wake without sleep");

   property p_cl2;
      @(posedge link_clk) disable iff (rst)
      (acc_rd && !cl3 ##1 run) |=> dq_oe_q;
   endproperty
   a_cl2: assert property (p_cl2) else $error("latency two late");

   property p_cl3;
      @(posedge link_clk) disable iff (rst)
      (acc_rd && cl3 ##1 run && !dq_oe_q ##1 run) |-> !dq_oe_q ##1 dq_oe_q;
   endproperty
   a_cl3: assert property (p_cl3) else $error("latency three wrong");

   property p_stop;
      @(posedge link_clk) disable iff (rst)
      acc_bst |=> !bst_active_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");

   property p_order;
      @(posedge link_clk) disable iff (rst)
      (cont && mr_q[`SDC_MR_BT]) |->
         ((seq_col ^ bst_start_q) & len_m1) == (bst_idx_q & len_m1);
   endproperty
   a_order: assert property (p_order) else $error("bad interleave");

   property p_autoclose;
      @(posedge link_clk) disable iff (rst)
      ap_start |=> ap_busy_q ##[1:6] !open_q[ap_bank_q];
   endproperty
   a_autoclose: assert property (p_autoclose) else $error("row not closed");

   property p_desel;
      @(posedge link_clk) disable iff (rst)
      pins.cs_n |=> $stable(mr_q);
   endproperty
   a_desel: assert property (p_desel) else $error("deselect acted");
endmodule
`default_nettype wire

// >>> core/sdc_defs.svh
/*
 * Constants for the memory front end: pin widths, array shape, the
 * mode word layout, command codes and the internal precharge time.
 * Assumes it is included by bare name before the package and modules.
 */
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// -----------------------------------------------------------------
// Array shape and pin widths
// -----------------------------------------------------------------
`define SDC_ADDR_W 12
`define SDC_DQ_W 16
`define SDC_BANKS 4
`define SDC_ROW_BITS 12
`define SDC_COL_BITS 9
`define SDC_AP_BIT 10

// -----------------------------------------------------------------
// Mode word layout and codes
// -----------------------------------------------------------------
`define SDC_MR_BL_MSB 2
`define SDC_MR_BL_LSB 0
`define SDC_MR_BT 3
`define SDC_MR_CL_MSB 6
`define SDC_MR_CL_LSB 4
`define SDC_MR_RESET 12'h030
`define SDC_CL2 3'h2
`define SDC_CL3 3'h3
`define SDC_BL1 3'h0
`define SDC_BL2 3'h1
`define SDC_BL4 3'h2
`define SDC_BL8 3'h3
`define SDC_BL_PAGE 3'h7

// -----------------------------------------------------------------
// Command codes on {row strobe, column strobe, write enable}
// -----------------------------------------------------------------
`define SDC_OP_NOP 3'h7
`define SDC_OP_ACT 3'h3
`define SDC_OP_RD 3'h5
`define SDC_OP_WR 3'h4
`define SDC_OP_BST 3'h6
`define SDC_OP_PRE 3'h2
`define SDC_OP_REF 3'h1
`define SDC_OP_MRS 3'h0

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SDC_TRP_NS 18
`define SDC_LINK_NS 6

`endif

// >>> core/sdc_pkg.sv
/*
 * Types shared by the memory front end: commands, power states,
 * the command pin bundle and the status bundle.
 * Assumes sdc_defs.svh is available for inclusion.
 */
package sdc_pkg;

   // -----------------------------------------------------------------
   // Enumerations
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
      CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
   } sdc_cmd_t;

   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF} sdc_pwr_t;

   // -----------------------------------------------------------------
   // Bundles
   // -----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdc_pins_t;

   typedef struct packed {
      logic power_down;
      logic self_refresh;
      logic burst_busy;
      logic [3:0] banks_open;
   } sdc_status_t;

endpackage

// >>> core/sdc_burst_col.sv
/*
 * Column generator for one burst word: wraps within the burst length,
 * in linear or interleaved order.
 * Assumes len_m1 is the burst length minus one, all ones for full page.
 */
`timescale 1ns/1ps
`default_nettype none
module sdc_burst_col #(
   parameter int COL_BITS = 9
) (
   // Burst description
   input wire logic [COL_BITS-1:0] start,
   input wire logic [COL_BITS-1:0] idx,
   input wire logic [COL_BITS-1:0] len_m1,
   input wire logic interleave,
   // Column for this word
   output logic [COL_BITS-1:0] col
);
   logic [COL_BITS-1:0] low;

   always_comb begin
      if (interleave) begin
         low = start ^ idx;
      end else begin
         low = start + idx;
      end
      // Bits above the burst window stay at the start column.
      col = (start & ~len_m1) | (low & len_m1);
   end
endmodule
`default_nettype wire

// >>> bench/sdc_ctrl_model.sv
/*
 * Controller model: makes the link clock and drives commands, bank,
 * address, write data and clock enable on its falling edge.
 * Assumes callers invoke the tasks at a falling link clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_ctrl_model (
   // Link clock and clock enable
   output logic link_clk,
   output logic cke,
   // Command and address pins
   output sdc_pkg::sdc_pins_t pins,
   output logic bank_select_lsb,
   output logic bank_select_msb,
   output logic [`SDC_ADDR_W-1:0] addr,
   // Write data and masks
   output logic [1:0] dqm,
   output logic [`SDC_DQ_W-1:0] dq_in
);
   import sdc_pkg::*;

   // -----------------------------------------------------------------
   // Clock and idle levels
   // -----------------------------------------------------------------
   // The odd start offset keeps the link unrelated in phase to the core.
   initial begin
      link_clk = 1'b0;
      cke = 1'b1;
      pins = 4'hF;
      {bank_select_msb, bank_select_lsb} = 2'h0;
      addr = 12'h000;
      dqm = 2'h0;
      dq_in = 16'h0000;
      #1.3;
      forever #(`SDC_LINK_NS / 2.0) link_clk = ~link_clk;
   end

   // -----------------------------------------------------------------
   // Pin tasks
   // -----------------------------------------------------------------
   // Presents one command, sampled at the next rising edge.
   task automatic cmd(input logic [3:0] p, input logic [1:0] bank,
                      input logic [11:0] a, input logic [15:0] d);
      pins <= p;
      {bank_select_msb, bank_select_lsb} <= bank;
      addr <= a;
      dq_in <= d;
      @(negedge link_clk);
   endtask

   // Next write word of a burst, with no command beside it.
   task automatic wdata(input logic [15:0] d);
      pins <= {1'b0, `SDC_OP_NOP};
      dq_in <= d;
      @(negedge link_clk);
   endtask

   // Idle cycles; released write data toggles so nothing stale looks valid.
   task automatic tick(input int n);
      pins <= {1'b0, `SDC_OP_NOP};
      dq_in <= ~dq_in;
      repeat (n) @(negedge link_clk);
   endtask

   task automatic set_cke(input logic v);
      cke <= v;
   endtask

   // Byte masks apply to the write sampled at the next rising edge.
   task automatic set_dqm(input logic [1:0] m);
      dqm <= m;
   endtask
endmodule
`default_nettype wire

// >>> bench/tb_sdram_clock_gate_and_access.sv
/*
 * Self-checking bench for the memory front end: bursts, latencies,
 * orders, suspend, auto-close and low-power entry and exit.
 * Assumes the controller model drives every link-side pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   error_cnt++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_sdram_clock_gate_and_access;
   import sdc_pkg::*;

   // -----------------------------------------------------------------
   // Signals and constants
   // -----------------------------------------------------------------
   localparam logic [3:0] ACT = {1'b0, `SDC_OP_ACT};
   localparam logic [3:0] RD = {1'b0, `SDC_OP_RD};
   localparam logic [3:0] WR = {1'b0, `SDC_OP_WR};
   localparam logic [3:0] BST = {1'b0, `SDC_OP_BST};
   localparam logic [3:0] PRE = {1'b0, `SDC_OP_PRE};
   localparam logic [3:0] REF = {1'b0, `SDC_OP_REF};
   localparam logic [3:0] MRS = {1'b0, `SDC_OP_MRS};
   localparam logic [3:0] DSEL_RD = {1'b1, `SDC_OP_RD};
   localparam logic [15:0] D[4] = '{16'hA000, 16'hA001, 16'hA002, 16'hA003};
   localparam logic [15:0] SUS[5] = '{16'hA001, 16'hA002, 16'hA002,
                                     16'hA003, 16'hA000};
   logic core_clk;
   logic rst;
   logic link_clk;
   logic cke;
   logic bank_select_lsb;
   logic bank_select_msb;
   logic [1:0] dqm;
   logic [11:0] addr;
   logic [15:0] dq_in;
   logic [15:0] dq_out_q;
   logic dq_oe_q;
   sdc_pins_t pins;
   sdc_status_t status_q;
   int error_cnt;
   int tests_run;

   sdc_sdram_front #(.ROW_BITS(4), .COL_BITS(4)) sdc_sdram_front_i (
      .core_clk(core_clk), .rst(rst), .status_q(status_q),
      .link_clk(link_clk), .cke(cke), .pins(pins),
      .bank_select_lsb(bank_select_lsb), .bank_select_msb(bank_select_msb),
      .addr(addr), .dqm(dqm), .dq_in(dq_in),
      .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q));

   sdc_ctrl_model sdc_ctrl_model_i (
      .link_clk(link_clk), .cke(cke), .pins(pins),
      .bank_select_lsb(bank_select_lsb), .bank_select_msb(bank_select_msb),
      .addr(addr), .dqm(dqm), .dq_in(dq_in));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Status crosses through synchronisers, so allow it time to settle.
   task automatic wait_core();
      repeat (10) @(negedge core_clk);
      @(negedge link_clk);
   endtask

   task automatic act(input logic [1:0] b, input logic [11:0] row);
      sdc_ctrl_model_i.cmd(ACT, b, row, 16'h0000);
      sdc_ctrl_model_i.tick(3);
   endtask

   // Mode set is only taken with every bank closed.
   task automatic set_mode(input logic [2:0] cl, input logic bt,
                           input logic [2:0] bl);
      sdc_ctrl_model_i.cmd(PRE, 2'h0, 12'h400, 16'h0000);
      sdc_ctrl_model_i.tick(4);
      sdc_ctrl_model_i.cmd(MRS, 2'h0, {5'h00, cl, bt, bl}, 16'h0000);
      sdc_ctrl_model_i.tick(2);
   endtask

   task automatic rd_chk(input logic [1:0] b, input logic [11:0] c,
                         input int lat, input logic [15:0] e[4], input int n);
      sdc_ctrl_model_i.cmd(RD, b, c, 16'h0000);
      sdc_ctrl_model_i.tick(lat - 1);
      for (int i = 0; i < n; i++) begin
         `CHK("dq_oe_q", 1'b1, dq_oe_q)
         `CHK("dq_out_q", e[i], dq_out_q)
         sdc_ctrl_model_i.tick(1);
      end
   endtask

   // -----------------------------------------------------------------
   // Watchdog: the sequence needs about 3 us; allow far more.
   // -----------------------------------------------------------------
   initial begin
      #60000;
      error_cnt++;
      end_sim();
   end

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      error_cnt = 0;
      tests_run = 0;
      repeat (12) @(negedge core_clk);
      `CHK("status_q", 7'h00, status_q)
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      `CHK("dq_out_q", 16'h0000, dq_out_q)
      rst = 1'b0;
      sdc_ctrl_model_i.tick(2);
      set_mode(`SDC_CL2, 1'b0, `SDC_BL2);
      act(2'h1, 12'h002);
      sdc_ctrl_model_i.cmd(WR, 2'h1, 12'h004, D[0]);
      sdc_ctrl_model_i.wdata(D[1]);
      sdc_ctrl_model_i.cmd(WR, 2'h1, 12'h006, D[2]);
      sdc_ctrl_model_i.wdata(D[3]);
      sdc_ctrl_model_i.tick(2);
      rd_chk(2'h1, 12'h004, 2, D, 2);
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      sdc_ctrl_model_i.cmd(DSEL_RD, 2'h1, 12'h004, 16'h0000);
      sdc_ctrl_model_i.tick(4);
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      set_mode(`SDC_CL3, 1'b1, `SDC_BL4);
      act(2'h1, 12'h002);
      rd_chk(2'h1, 12'h005, 3, '{D[1], D[0], D[3], D[2]}, 4);
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      set_mode(`SDC_CL2, 1'b0, `SDC_BL4);
      act(2'h1, 12'h002);
      sdc_ctrl_model_i.cmd(RD, 2'h1, 12'h005, 16'h0000);
      sdc_ctrl_model_i.tick(1);
      for (int i = 0; i < 5; i++) begin
         `CHK("dq_oe_q", 1'b1, dq_oe_q)
         `CHK("dq_out_q", SUS[i], dq_out_q)
         sdc_ctrl_model_i.set_cke(i != 0);
         sdc_ctrl_model_i.tick(1);
      end
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      set_mode(`SDC_CL2, 1'b0, `SDC_BL_PAGE);
      act(2'h1, 12'h002);
      rd_chk(2'h1, 12'h004, 2, D, 4);
      `CHK("dq_oe_q", 1'b1, dq_oe_q)
      wait_core();
      `CHK("burst_busy", 1'b1, status_q.burst_busy)
      sdc_ctrl_model_i.cmd(BST, 2'h1, 12'h000, 16'h0000);
      sdc_ctrl_model_i.tick(4);
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      set_mode(`SDC_CL2, 1'b0, `SDC_BL1);
      act(2'h2, 12'h001);
      wait_core();
      `CHK("banks_open", 4'h4, status_q.banks_open)
      sdc_ctrl_model_i.cmd(WR, 2'h2, 12'h403, 16'hB0B0);
      sdc_ctrl_model_i.tick(8);
      wait_core();
      `CHK("banks_open", 4'h0, status_q.banks_open)
      sdc_ctrl_model_i.cmd(RD, 2'h2, 12'h003, 16'h0000);
      sdc_ctrl_model_i.tick(3);
      `CHK("dq_oe_q", 1'b0, dq_oe_q)
      act(2'h2, 12'h001);
      rd_chk(2'h2, 12'h003, 2, '{16'hB0B0, D[1], D[2], D[3]}, 1);
      sdc_ctrl_model_i.set_dqm(2'h1);
      sdc_ctrl_model_i.cmd(WR, 2'h2, 12'h003, 16'hC1C1);
      sdc_ctrl_model_i.set_dqm(2'h0);
      sdc_ctrl_model_i.tick(2);
      rd_chk(2'h2, 12'h003, 2, '{16'hC1B0, D[1], D[2], D[3]}, 1);
      sdc_ctrl_model_i.cmd(PRE, 2'h0, 12'h400, 16'h0000);
      sdc_ctrl_model_i.tick(6);
      sdc_ctrl_model_i.set_cke(1'b0);
      sdc_ctrl_model_i.tick(2);
      wait_core();
      `CHK("power_down", 1'b1, status_q.power_down)
      sdc_ctrl_model_i.cmd(ACT, 2'h0, 12'h001, 16'h0000);
      sdc_ctrl_model_i.tick(2);
      wait_core();
      `CHK("banks_open", 4'h0, status_q.banks_open)
      sdc_ctrl_model_i.set_cke(1'b1);
      sdc_ctrl_model_i.tick(2);
      wait_core();
      `CHK("power_down", 1'b0, status_q.power_down)
      sdc_ctrl_model_i.set_cke(1'b0);
      sdc_ctrl_model_i.cmd(REF, 2'h0, 12'h000, 16'h0000);
      sdc_ctrl_model_i.tick(2);
      wait_core();
      `CHK("self_refresh", 1'b1, status_q.self_refresh)
      sdc_ctrl_model_i.set_cke(1'b1);
      sdc_ctrl_model_i.tick(2);
      wait_core();
      `CHK("self_refresh", 1'b0, status_q.self_refresh)
      end_sim();
   end
endmodule
`default_nettype wire
